// >>> rtl/dchan_byte_timer.sv
// Periodic byte tick generator for the D channel register path.
`include "dchan_consts.svh"

module dchan_byte_timer
    import dchan_pkg::*;
#(
    parameter logic [`DCH_TIMER_W-1:0] PERIOD_CYCLES = `DCH_TIMER_W'(
        `DCH_BYTE_PERIOD_US * `DCH_CLK_MHZ)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic tick_q
);

    logic [`DCH_TIMER_W-1:0] count_q;

    // ======================================================
    // Count down one period; restart from full when stopped so
    // the first byte arrives one whole period after enabling.
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            count_q <= PERIOD_CYCLES - `DCH_TIMER_W'(1);
            tick_q <= 1'b0;
        end else if (count_q == '0) begin
            count_q <= PERIOD_CYCLES - `DCH_TIMER_W'(1);
            tick_q <= 1'b1;
        end else begin
            count_q <= count_q - `DCH_TIMER_W'(1);
            tick_q <= 1'b0;
        end
    end

endmodule

// >>> rtl/dchan_consts.svh
// Constants for register-based D channel byte access.
`ifndef DCHAN_CONSTS_SVH
`define DCHAN_CONSTS_SVH

// ==========================================================
// Register indices on the control port.
`define DCH_ADDR_W 4
`define DCH_ADDR_RESET 4'h0
`define DCH_ADDR_CAUSE 4'h1
`define DCH_ADDR_ACT_CTRL 4'h2
`define DCH_ADDR_IRQ_STAT 4'h3
`define DCH_ADDR_IRQ_MASK 4'h4
`define DCH_ADDR_ACCESS 4'h5
`define DCH_ADDR_DATA 4'h6

// ==========================================================
// Field positions.
`define DCH_BIT_SOFT_RESET 3
`define DCH_BIT_PORT_ACCESS 1
`define DCH_BIT_ACT_REQ 3
`define DCH_BIT_CUST_EN 0
`define DCH_BIT_ACT_IRQ 3
`define DCH_BIT_OVERRUN 2

// ==========================================================
// Reset values and cause codes.
`define DCH_SOFT_RESET_RST 1'b1
`define DCH_BYTE_RST 8'h00
`define DCH_NIBBLE_RST 4'h0
`define DCH_CAUSE_BYTE 4'hf

// ==========================================================
// Timing: byte period in microseconds and clock rate in MHz.
`define DCH_BYTE_PERIOD_US 500
`define DCH_CLK_MHZ 100
`define DCH_TIMER_W 16

`endif

// >>> rtl/dchan_pkg.sv
// Types shared by the D channel register access design.
package dchan_pkg;

    // Byte interrupt state, Gray coded along idle, unread, held.
    typedef enum logic [1:0] {
        DCH_IDLE = 2'b00,
        DCH_UNREAD = 2'b01,
        DCH_ACT_HELD = 2'b11
    } dch_state_t;

endpackage

// >>> rtl/dchan_register_access.sv
// Register-based D channel byte access with combined interrupt.
//
// Behaviour
// - Active access moves both link bytes through the data register.
// - Each new received byte loads cause nibble 1111 when enabled.
// - Byte interrupt repeats every 500 microseconds during access.
// - Activation colliding with a byte interrupt waits for a data read.
// - Combined interrupt shows in the flag bit; host tests it first.
// - Successful initial activation puts code A or B in cause nibble.
// - Error puts code 4 in cause nibble; host gives up activation.
`include "dchan_consts.svh"

module dchan_register_access
    import dchan_pkg::*;
#(
    parameter logic [`DCH_TIMER_W-1:0] BYTE_PERIOD_CYCLES = `DCH_TIMER_W'(
        `DCH_BYTE_PERIOD_US * `DCH_CLK_MHZ)
) (
    input wire logic clk,
    input wire logic rst,
    // Control port.
    input wire logic [`DCH_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [7:0] rdata_q,
    output logic irq_q,
    // Status from the rest of the transceiver, same clock.
    input wire logic activation_done,
    input wire logic transparent_enabled,
    input wire logic act_event,
    input wire logic [3:0] act_code,
    input wire logic [7:0] rx_dchan_byte,
    // Controls and data toward the transceiver.
    output logic soft_reset_q,
    output logic activation_request_q,
    output logic customer_data_enable_q,
    output logic dchan_access_active_q,
    output logic [7:0] tx_dchan_byte_q,
    output logic tx_dchan_strobe_q
);

    // ======================================================
    // Address decode shared by the write and read paths.
    function automatic logic hit(
        input logic [`DCH_ADDR_W-1:0] a,
        input logic [`DCH_ADDR_W-1:0] idx
    );
        hit = (a == idx);
    endfunction

    logic dchan_port_access_enable_q;
    logic [7:0] irq_mask_reg_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_stat_set;
    logic [7:0] irq_stat_clr;
    logic [3:0] irq_cause_nibble_q;
    logic [3:0] held_code_q;
    logic [7:0] dchan_rx_q;
    logic [7:0] dchan_data_reg_q;
    dch_state_t state_q;
    dch_state_t state_d;
    logic access_ok;
    logic byte_tick;
    logic byte_irq_en;
    logic data_rd;
    logic byte_rep;
    logic act_now;
    logic act_hold;
    logic act_release;

    // ======================================================
    // Access gate: all conditions must hold before the timer
    // runs and the data register carries link bytes.
    assign access_ok = !soft_reset_q && activation_done
        && transparent_enabled
        && dchan_port_access_enable_q;

    // Byte interrupt needs the mask bit as well as access.
    assign byte_irq_en = irq_mask_reg_q[`DCH_BIT_ACT_IRQ]
        && dchan_port_access_enable_q;

    assign data_rd = re && hit(addr, `DCH_ADDR_DATA);

    // A reported byte is one that reaches the cause nibble.
    assign byte_rep = byte_tick && byte_irq_en;

    dchan_byte_timer #(
        .PERIOD_CYCLES(BYTE_PERIOD_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .run(access_ok),
        .tick_q(byte_tick)
    );

    // ======================================================
    // Activation collision handling. An activation event is
    // reported at once only when no byte interrupt is pending
    // or arriving; otherwise its code is parked until the host
    // reads the data register, so the byte code is not lost.
    assign act_now = act_event && (state_q == DCH_IDLE)
        && !byte_rep;
    assign act_hold = act_event && !act_now;
    assign act_release = (state_q == DCH_ACT_HELD) && !byte_rep
        && (data_rd || !access_ok);

    // Next state of the byte interrupt tracker.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DCH_IDLE: begin
                if (act_hold) begin
                    state_d = DCH_ACT_HELD;
                end else if (byte_rep) begin
                    state_d = DCH_UNREAD;
                end
            end
            DCH_UNREAD: begin
                if (act_hold) begin
                    state_d = DCH_ACT_HELD;
                end else if (data_rd && !byte_rep) begin
                    state_d = DCH_IDLE;
                end
            end
            DCH_ACT_HELD: begin
                if (act_release) begin
                    state_d = DCH_IDLE;
                end
            end
            default: begin
                state_d = DCH_IDLE;
            end
        endcase
        // A parked code leaves only through its release, so a last
        // tick landing as access drops cannot discard it.
        if (!access_ok && !act_hold
            && state_q != DCH_ACT_HELD) begin
            state_d = DCH_IDLE;
        end
    end

    // Tracker state register.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= DCH_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Parked activation code; a later collision overwrites it
    // because only the newest activation result matters.
    always_ff @(posedge clk) begin
        if (rst) begin
            held_code_q <= `DCH_NIBBLE_RST;
        end else if (act_hold) begin
            held_code_q <= act_code;
        end
    end

    // ======================================================
    // Cause nibble. The byte code takes priority in its cycle;
    // an activation in that cycle is parked, not dropped.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_cause_nibble_q <= `DCH_NIBBLE_RST;
        end else if (byte_rep) begin
            irq_cause_nibble_q <= `DCH_CAUSE_BYTE;
        end else if (act_now) begin
            irq_cause_nibble_q <= act_code;
        end else if (act_release) begin
            irq_cause_nibble_q <= held_code_q;
        end
    end

    // ======================================================
    // Sticky interrupt status, write one to clear. A set in
    // the same cycle as its clear wins, so no event is lost.
    always_comb begin
        irq_stat_set = 8'h00;
        irq_stat_set[`DCH_BIT_ACT_IRQ] = byte_rep || act_now
            || act_release;
        irq_stat_set[`DCH_BIT_OVERRUN] = byte_rep
            && (state_q != DCH_IDLE) && !data_rd;
        irq_stat_clr = (we && hit(addr, `DCH_ADDR_IRQ_STAT))
            ? wdata : 8'h00;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_stat
            // One sticky bit per status position.
            always_ff @(posedge clk) begin
                if (rst) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (irq_stat_set[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (irq_stat_clr[gi]) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt, one cycle behind the status it shows.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_reg_q);
        end
    end

    // ======================================================
    // Host-written control registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_reset_q <= `DCH_SOFT_RESET_RST;
        end else if (we && hit(addr, `DCH_ADDR_RESET)) begin
            soft_reset_q <= wdata[`DCH_BIT_SOFT_RESET];
        end
    end

    // Activation request and customer data enable.
    always_ff @(posedge clk) begin
        if (rst) begin
            activation_request_q <= 1'b0;
            customer_data_enable_q <= 1'b0;
        end else if (we && hit(addr, `DCH_ADDR_ACT_CTRL)) begin
            activation_request_q <= wdata[`DCH_BIT_ACT_REQ];
            customer_data_enable_q <= wdata[`DCH_BIT_CUST_EN];
        end
    end

    // Interrupt mask, same layout as the status register.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_reg_q <= 8'h00;
        end else if (we && hit(addr, `DCH_ADDR_IRQ_MASK)) begin
            irq_mask_reg_q <= wdata;
        end
    end

    // Port access enable for the data register.
    always_ff @(posedge clk) begin
        if (rst) begin
            dchan_port_access_enable_q <= 1'b0;
        end else if (we && hit(addr, `DCH_ADDR_ACCESS)) begin
            dchan_port_access_enable_q <=
                wdata[`DCH_BIT_PORT_ACCESS];
        end
    end

    // ======================================================
    // Byte path. The host's transmit byte is held until the
    // next tick, so a late write simply repeats the old status.
    always_ff @(posedge clk) begin
        if (rst) begin
            dchan_data_reg_q <= `DCH_BYTE_RST;
        end else if (we && hit(addr, `DCH_ADDR_DATA)) begin
            dchan_data_reg_q <= wdata;
        end
    end

    // Received byte and transmit hand-off on each tick.
    always_ff @(posedge clk) begin
        if (rst) begin
            dchan_rx_q <= `DCH_BYTE_RST;
            tx_dchan_byte_q <= `DCH_BYTE_RST;
            tx_dchan_strobe_q <= 1'b0;
        end else begin
            tx_dchan_strobe_q <= byte_tick;
            if (byte_tick) begin
                dchan_rx_q <= rx_dchan_byte;
                tx_dchan_byte_q <= dchan_data_reg_q;
            end
        end
    end

    // Access state made visible to the transceiver.
    always_ff @(posedge clk) begin
        if (rst) begin
            dchan_access_active_q <= 1'b0;
        end else begin
            dchan_access_active_q <= access_ok;
        end
    end

    // ======================================================
    // Read data stand one cycle after the strobe, zero else.
    // Reading the data register returns the received byte,
    // not the host's own transmit byte.
    always_ff @(posedge clk) begin
        if (rst || !re) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (addr)
                `DCH_ADDR_RESET: begin
                    rdata_q <= {4'h0, soft_reset_q, 3'h0};
                end
                `DCH_ADDR_CAUSE: begin
                    rdata_q <= {4'h0, irq_cause_nibble_q};
                end
                `DCH_ADDR_ACT_CTRL: begin
                    rdata_q <= {4'h0, activation_request_q, 2'h0,
                        customer_data_enable_q};
                end
                `DCH_ADDR_IRQ_STAT: begin
                    rdata_q <= irq_stat_q;
                end
                `DCH_ADDR_IRQ_MASK: begin
                    rdata_q <= irq_mask_reg_q;
                end
                `DCH_ADDR_ACCESS: begin
                    rdata_q <= {5'h00, access_ok,
                        dchan_port_access_enable_q, 1'b0};
                end
                `DCH_ADDR_DATA: begin
                    rdata_q <= dchan_rx_q;
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

endmodule

// >>> test/dchan_host_model.sv
// Host model that drives the control port of the D channel block.
`include "dchan_consts.svh"

module dchan_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata_q,
    output logic [`DCH_ADDR_W-1:0] addr,
    output logic [7:0] wdata,
    output logic we,
    output logic re
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus before the first access.
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        we = 1'b0;
        re = 1'b0;
    end

    // ==========================================================
    // Bus cycles
    // Released address and data are inverted so stale values never
    // look valid to the block.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        // Let the write settle so callers see the updated register.
        #1;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata_q;
    endtask

    // Power-up bring-up of register-based D channel access.
    task automatic setup();
        wr(`DCH_ADDR_RESET, 8'h00);
        wr(`DCH_ADDR_ACCESS, 8'h02);
        wr(`DCH_ADDR_IRQ_MASK, 8'h08);
        wr(`DCH_ADDR_ACT_CTRL, 8'h08);
    endtask

    // Interrupt handler; flag is cleared before the data read so a
    // parked activation that the read releases is not lost.
    task automatic isr(input logic [7:0] tx, output logic [3:0] cause,
                       output logic [7:0] rx);
        logic [7:0] v;
        rx = 8'h00;
        cause = 4'h0;
        rd(`DCH_ADDR_IRQ_STAT, v);
        if (v[3] === 1'b1) begin
            wr(`DCH_ADDR_IRQ_STAT, 8'h08);
            rd(`DCH_ADDR_CAUSE, v);
            cause = v[3:0];
            if (cause === 4'hf) begin
                wr(`DCH_ADDR_DATA, tx);
                rd(`DCH_ADDR_DATA, rx);
            end else if (cause === 4'ha || cause === 4'hb) begin
                wr(`DCH_ADDR_ACT_CTRL, 8'h09);
            end else if (cause === 4'h4) begin
                wr(`DCH_ADDR_IRQ_MASK, 8'h00);
            end
        end
    endtask
endmodule

// >>> test/dchan_register_access_properties.sv
// Port-level assertions for the D channel register access block.
`include "dchan_consts.svh"

module dchan_register_access_properties #(
    parameter logic [`DCH_TIMER_W-1:0] BYTE_PERIOD_CYCLES = 16'd50000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`DCH_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    input wire logic [7:0] rdata_q,
    input wire logic irq_q,
    input wire logic activation_done,
    input wire logic transparent_enabled,
    input wire logic act_event,
    input wire logic [3:0] act_code,
    input wire logic [7:0] rx_dchan_byte,
    input wire logic soft_reset_q,
    input wire logic activation_request_q,
    input wire logic customer_data_enable_q,
    input wire logic dchan_access_active_q,
    input wire logic [7:0] tx_dchan_byte_q,
    input wire logic tx_dchan_strobe_q
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [15:0] gap_q;
    logic armed_q;

    // ==========================================================
    // Byte period tracking
    // The gap is only trusted while access stays up, since a drop
    // restarts the timer with a full period.
    always_ff @(posedge clk) begin
        if (rst || tx_dchan_strobe_q) begin
            gap_q <= 16'h0001;
        end else begin
            gap_q <= gap_q + 16'h0001;
        end
        if (rst || !dchan_access_active_q) begin
            armed_q <= 1'b0;
        end else if (tx_dchan_strobe_q) begin
            armed_q <= 1'b1;
        end
    end

    chk_byte_period: assert property (
        tx_dchan_strobe_q && armed_q |-> gap_q == BYTE_PERIOD_CYCLES)
        else $error("byte strobe off its period");
    chk_strobe_needs_access: assert property (
        tx_dchan_strobe_q |-> $past(dchan_access_active_q))
        else $error("byte strobe without access");
    chk_strobe_one_cycle: assert property (
        tx_dchan_strobe_q |=> !tx_dchan_strobe_q)
        else $error("byte strobe longer than one cycle");
    chk_tx_byte_hold: assert property (
        !tx_dchan_strobe_q |-> $stable(tx_dchan_byte_q))
        else $error("tx byte moved without strobe");
    chk_rdata_idle_zero: assert property (
        !$past(re) |-> rdata_q == 8'h00)
        else $error("read data outside read slot");
    chk_access_gate: assert property (
        $past(soft_reset_q) || !$past(activation_done)
        || !$past(transparent_enabled) |-> !dchan_access_active_q)
        else $error("access active without its conditions");
    chk_irq_has_cause: assert property (
        $rose(irq_q) |-> $past(tx_dchan_strobe_q) || $past(act_event, 2)
        || $past(re, 2) || $past(we, 2) || ($past(dchan_access_active_q, 2)
        && !$past(dchan_access_active_q)))
        else $error("interrupt rose with no cause");
    chk_soft_reset_write: assert property (
        we && addr == `DCH_ADDR_RESET |=> soft_reset_q == $past(wdata[3]))
        else $error("soft reset bit not written");
    chk_ctrl_write: assert property (
        we && addr == `DCH_ADDR_ACT_CTRL |=>
        activation_request_q == $past(wdata[3])
        && customer_data_enable_q == $past(wdata[0]))
        else $error("control bits not written");
endmodule

// >>> test/tb.sv
// Top testbench for the D channel register access block.
`include "dchan_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PERIOD = 16'd40;
    logic clk, rst, we, re, irq_q, act_event, soft_reset_q;
    logic activation_done, transparent_enabled, tx_dchan_strobe_q;
    logic activation_request_q, customer_data_enable_q;
    logic dchan_access_active_q;
    logic [3:0] addr, act_code, c;
    logic [7:0] wdata, rdata_q, rx_dchan_byte, tx_dchan_byte_q, v;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int t1;

    dchan_register_access #(
        .BYTE_PERIOD_CYCLES(PERIOD)
    ) u_dchan_register_access (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata_q(rdata_q), .irq_q(irq_q), .activation_done(activation_done),
        .transparent_enabled(transparent_enabled), .act_event(act_event),
        .act_code(act_code), .rx_dchan_byte(rx_dchan_byte),
        .soft_reset_q(soft_reset_q),
        .activation_request_q(activation_request_q),
        .customer_data_enable_q(customer_data_enable_q),
        .dchan_access_active_q(dchan_access_active_q),
        .tx_dchan_byte_q(tx_dchan_byte_q),
        .tx_dchan_strobe_q(tx_dchan_strobe_q)
    );
    dchan_host_model u_host (
        .clk(clk), .rdata_q(rdata_q), .addr(addr), .wdata(wdata), .we(we),
        .re(re)
    );

    // Free clock and a cycle count for period measurement.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ==========================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Bounded wait, sampled after the edge has settled.
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq_q !== 1'b1; i++) @(posedge clk) #1;
        chk({7'h00, irq_q}, 8'h01, "irq wait");
    endtask

    task automatic act(input logic [3:0] code);
        @(posedge clk);
        act_event <= 1'b1;
        act_code <= code;
        @(posedge clk);
        act_event <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk({7'h00, soft_reset_q}, 8'h01, "soft reset out");
        u_host.wr(4'hf, 8'hff);
        for (int a = 0; a < 16; a++) begin
            u_host.rd(4'(a), v);
            chk(v, (a == 0) ? 8'h08 : 8'h00, "reset value");
        end
    endtask

    // Both success codes set customer data enable via the handler.
    task automatic t_activate();
        logic [3:0] codes [2];
        codes = '{4'ha, 4'hb};
        u_host.setup();
        chk({7'h00, soft_reset_q}, 8'h00, "soft reset clear");
        chk({7'h00, activation_request_q}, 8'h01, "act req");
        foreach (codes[i]) begin
            act(codes[i]);
            wait_irq(8);
            u_host.isr(8'h00, c, v);
            chk({4'h0, c}, {4'h0, codes[i]}, "success code");
            chk({7'h00, customer_data_enable_q}, 8'h01, "cust en");
            chk({7'h00, irq_q}, 8'h00, "irq cleared");
        end
    endtask

    // Two bytes each way, one period apart.
    task automatic t_stream();
        @(posedge clk);
        activation_done <= 1'b1;
        transparent_enabled <= 1'b1;
        rx_dchan_byte <= 8'h5a;
        wait_irq(60);
        t1 = cyc;
        u_host.isr(8'h3c, c, v);
        chk({4'h0, c}, 8'h0f, "byte cause");
        chk(v, 8'h5a, "rx byte");
        @(posedge clk);
        rx_dchan_byte <= 8'ha5;
        wait_irq(60);
        chk(8'(cyc - t1), PERIOD[7:0], "byte period");
        chk(tx_dchan_byte_q, 8'h3c, "tx byte");
        u_host.isr(8'hc3, c, v);
        chk(v, 8'ha5, "rx byte 2");
    endtask

    // Activation error arrives while a byte is unread.
    task automatic t_collide();
        wait_irq(60);
        act(4'h4);
        u_host.rd(`DCH_ADDR_CAUSE, v);
        chk(v, 8'h0f, "parked cause");
        u_host.wr(`DCH_ADDR_IRQ_STAT, 8'h08);
        u_host.rd(`DCH_ADDR_DATA, v);
        u_host.rd(`DCH_ADDR_CAUSE, v);
        chk(v, 8'h04, "released cause");
        wait_irq(4);
        u_host.isr(8'h00, c, v);
        chk({4'h0, c}, 8'h04, "error code");
        repeat (2 * PERIOD) @(posedge clk);
        #1;
        chk({7'h00, irq_q}, 8'h00, "masked irq");
        // With the mask off, ticks must not load the byte code.
        u_host.rd(`DCH_ADDR_CAUSE, v);
        chk(v, 8'h04, "cause kept while masked");
        @(posedge clk);
        activation_done <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, dchan_access_active_q}, 8'h00, "access off");
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence after a four-cycle reset.
    initial begin
        rst = 1'b1;
        activation_done = 1'b0;
        transparent_enabled = 1'b0;
        act_event = 1'b0;
        act_code = 4'h0;
        rx_dchan_byte = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_activate();
        t_stream();
        t_collide();
        test_done();
    end

    // The run needs well under 1000 cycles; this cuts a hang short.
    initial begin
        #50us;
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule

bind dchan_register_access dchan_register_access_properties #(
    .BYTE_PERIOD_CYCLES(BYTE_PERIOD_CYCLES)
) u_props (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata_q(rdata_q), .irq_q(irq_q), .activation_done(activation_done),
    .transparent_enabled(transparent_enabled), .act_event(act_event),
    .act_code(act_code), .rx_dchan_byte(rx_dchan_byte),
    .soft_reset_q(soft_reset_q),
    .activation_request_q(activation_request_q),
    .customer_data_enable_q(customer_data_enable_q),
    .dchan_access_active_q(dchan_access_active_q),
    .tx_dchan_byte_q(tx_dchan_byte_q),
    .tx_dchan_strobe_q(tx_dchan_strobe_q)
);
